// >>> rtl/drsw_consts.svh
// Constants of the descriptor ring and status write-back block.
// Assumes inclusion by the package, the top module and the testbench.
// What this block does
// - Ring end flag set: next descriptor comes from the list base address.
// - Chain flag set: second address word points at the next descriptor.
// - Buffer 2 size at bits 21:11; zero skips it, next descriptor fetched.
// - Buffer 1 size at bits 10:0; zero skips to buffer 2.
// - Overflow or watchdog: runt zero; overflow also late collision zero.
// - Receive collision after 512 bit times reports runt as zero.
// - Runt under 14 bytes: frame type and filter fail not valid.
// - Transmit ownership bit 31 cleared when frame done or buffers empty.
// - Error summary bit 15 is OR of six transmit error bits.
// - Jabber timeout sets bit 14, interrupt bit 3, aborts, stops.
// - Carrier lost bit 11, no carrier bit 10; invalid in loopback 01.
// - Late collision past 64 bytes aborts, sets bit 9; invalid on underflow.
// - Sixteen successive collisions abort and set bit 8.
// - Heartbeat fail bit 7 only at 10 Mb/s; invalid on underflow.
// - Collision tally at bits 6:3; invalid with excessive collisions.
// - Symbol mode bit 23: link fail bit 2 when link test failed.
// - FIFO empty mid-frame: abort, bit 1, suspend, interrupt bits 5 and 0.
// - Deferred bit 0 set when transmission waited on carrier.
// - Receive ownership bit 31 cleared when frame done or buffers full.
`ifndef DRSW_CONSTS_SVH
`define DRSW_CONSTS_SVH
`define DRSW_OWN_BIT       31
`define DRSW_RX_END_BIT    25
`define DRSW_RX_CHAIN_BIT  24
`define DRSW_SZ2_HI        21
`define DRSW_SZ2_LO        11
`define DRSW_SZ1_HI        10
`define DRSW_SZ1_LO        0
`define DRSW_TX_ES_BIT     15
`define DRSW_TX_TO_BIT     14
`define DRSW_TX_LO_BIT     11
`define DRSW_TX_NC_BIT     10
`define DRSW_TX_LC_BIT     9
`define DRSW_TX_EC_BIT     8
`define DRSW_TX_HF_BIT     7
`define DRSW_TX_CC_HI      6
`define DRSW_TX_CC_LO      3
`define DRSW_TX_LF_BIT     2
`define DRSW_TX_UF_BIT     1
`define DRSW_TX_DE_BIT     0
`define DRSW_RX_FF_BIT     30
`define DRSW_RX_RF_BIT     11
`define DRSW_RX_CS_BIT     6
`define DRSW_RX_FT_BIT     5
`define DRSW_RX_DB_BIT     2
`define DRSW_RX_CE_BIT     1
`define DRSW_IS_TI_BIT     0
`define DRSW_IS_TJ_BIT     3
`define DRSW_IS_TU_BIT     5
`define DRSW_OM_SYM_BIT    23
`define DRSW_OM_LB_HI      11
`define DRSW_OM_LB_LO      10
`define DRSW_LB_INTERNAL   2'h1
`define DRSW_COLL_LIMIT    5'h10
`define DRSW_RUNT_SHORT    11'h00E
`define DRSW_DESC_STRIDE   32'h00000010
`define DRSW_W1_OFS        32'h00000004
`define DRSW_W2_OFS        32'h00000008
`define DRSW_W3_OFS        32'h0000000C
`define DRSW_A_BASE        8'h00
`define DRSW_A_MODE        8'h04
`define DRSW_A_CUR         8'h08
`define DRSW_A_STAT        8'h0C
`define DRSW_A_TXSW        8'h10
`define DRSW_A_RXSW        8'h14
`endif

// >>> rtl/drsw_pkg.sv
// Types of the descriptor ring and status write-back block.
// Assumes the constants header lies on the include path.
`include "drsw_consts.svh"
package drsw_pkg;
	typedef enum logic [2:0] {
		DRSW_IDLE, DRSW_BUF1, DRSW_BUF2, DRSW_NEXT, DRSW_WB
	} drsw_walk_e;

	typedef struct packed {
		logic        ovf;
		logic        wdog;
		logic        late_coll;
		logic        runt;
		logic        ftype;
		logic        filt_fail;
		logic        dribble;
		logic        crc_err;
		logic [10:0] len;
	} drsw_rx_ev_s;

	typedef struct packed {
		logic       jabber;
		logic       carrier_lost;
		logic       no_carrier;
		logic       late_coll;
		logic       hb_fail;
		logic [4:0] colls;
		logic       link_fail;
		logic       fifo_empty;
		logic       deferred;
	} drsw_tx_ev_s;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} drsw_mem_s;
endpackage : drsw_pkg

// >>> rtl/drsw_top.sv
// Receive ring walker and transmit status write-back with AHB-Lite slave.
// Assumes one host-memory port that answers each request with mem_ack.
`timescale 1ns/1ps
`default_nettype none
`include "drsw_consts.svh"
module drsw_top (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [1:0]        htrans,
	input  wire logic [31:0]       haddr,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	output drsw_pkg::drsw_mem_s    mem_o,
	input  wire logic              mem_ack,
	input  wire logic [31:0]       mem_rdata,
	input  wire logic              rx_start,
	input  wire logic              rx_done,
	input  wire drsw_pkg::drsw_rx_ev_s rx_ev,
	input  wire logic              tx_done,
	input  wire drsw_pkg::drsw_tx_ev_s tx_ev,
	input  wire logic              speed_10,
	output logic                   tx_stop,
	output logic                   tx_suspend
);
	import drsw_pkg::*;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] mode;
		logic [31:0] cur;
		logic [31:0] ctl;
		logic [31:0] a1;
		logic [31:0] a2;
		logic [31:0] stat;
		logic [31:0] txsw;
		logic [31:0] rxsw;
		logic [31:0] rdata;
		logic        dph;
		logic        dwr;
		logic [7:0]  daddr;
		logic [1:0]  fetch;
		logic        pending;
		drsw_walk_e  st;
		drsw_mem_s   mem;
		logic        stop;
		logic        susp;
	} drsw_state_s;

	drsw_state_s s_ff;
	drsw_state_s nxt_s;
	logic [31:0] tx_word;
	logic [31:0] rx_word;
	logic        tx_err;
	logic [10:0] sz1;
	logic [10:0] sz2;

	assign sz1 = s_ff.ctl[`DRSW_SZ1_HI:`DRSW_SZ1_LO];
	assign sz2 = s_ff.ctl[`DRSW_SZ2_HI:`DRSW_SZ2_LO];

	always_comb begin
		logic lb;
		logic ec;
		lb = s_ff.mode[`DRSW_OM_LB_HI:`DRSW_OM_LB_LO] == `DRSW_LB_INTERNAL;
		ec = tx_ev.colls >= `DRSW_COLL_LIMIT;
		tx_word = '0;
		tx_word[`DRSW_TX_TO_BIT] = tx_ev.jabber;
		tx_word[`DRSW_TX_LO_BIT] = tx_ev.carrier_lost & ~lb;
		tx_word[`DRSW_TX_NC_BIT] = tx_ev.no_carrier & ~lb;
		tx_word[`DRSW_TX_LC_BIT] = tx_ev.late_coll & ~tx_ev.fifo_empty;
		tx_word[`DRSW_TX_EC_BIT] = ec;
		tx_word[`DRSW_TX_HF_BIT] = tx_ev.hb_fail & speed_10
			& ~tx_ev.fifo_empty & ~tx_ev.jabber;
		if (!ec)
			tx_word[`DRSW_TX_CC_HI:`DRSW_TX_CC_LO] = tx_ev.colls[3:0];
		tx_word[`DRSW_TX_LF_BIT] = tx_ev.link_fail
			& s_ff.mode[`DRSW_OM_SYM_BIT];
		tx_word[`DRSW_TX_UF_BIT] = tx_ev.fifo_empty;
		tx_word[`DRSW_TX_DE_BIT] = tx_ev.deferred;
		tx_err = tx_word[`DRSW_TX_UF_BIT] | tx_word[`DRSW_TX_EC_BIT]
			| tx_word[`DRSW_TX_LC_BIT] | tx_word[`DRSW_TX_NC_BIT]
			| tx_word[`DRSW_TX_LO_BIT] | tx_word[`DRSW_TX_TO_BIT];
		tx_word[`DRSW_TX_ES_BIT] = tx_err;
		tx_word[`DRSW_OWN_BIT] = 1'b0;
	end

	always_comb begin
		logic short_runt;
		short_runt = rx_ev.runt & (rx_ev.len < `DRSW_RUNT_SHORT);
		rx_word = '0;
		rx_word[`DRSW_RX_RF_BIT] = rx_ev.runt & ~rx_ev.ovf
			& ~rx_ev.wdog & ~rx_ev.late_coll;
		rx_word[`DRSW_RX_CS_BIT] = rx_ev.late_coll & ~rx_ev.ovf;
		rx_word[`DRSW_RX_FT_BIT] = rx_ev.ftype & ~short_runt;
		rx_word[`DRSW_RX_FF_BIT] = rx_ev.filt_fail & ~short_runt;
		rx_word[`DRSW_RX_DB_BIT] = rx_ev.dribble
			& ~rx_ev.ovf & ~rx_ev.wdog;
		rx_word[`DRSW_RX_CE_BIT] = rx_ev.crc_err & ~rx_ev.ovf & ~rx_ev.wdog;
		rx_word[`DRSW_OWN_BIT] = 1'b0;
	end

	always_comb begin
		logic [31:0] rd;
		nxt_s = s_ff;
		rd = '0;
		if (s_ff.dph && s_ff.dwr) begin
			case (s_ff.daddr)
				`DRSW_A_BASE: begin
					nxt_s.base = hwdata;
					nxt_s.cur = hwdata;
				end
				`DRSW_A_MODE: nxt_s.mode = hwdata;
				`DRSW_A_STAT: begin
					nxt_s.stat = s_ff.stat & ~hwdata;
					if (hwdata[`DRSW_IS_TJ_BIT])
						nxt_s.stop = 1'b0;
					if (hwdata[`DRSW_IS_TU_BIT])
						nxt_s.susp = 1'b0;
				end
				default: nxt_s.rdata = s_ff.rdata;
			endcase
		end
		nxt_s.dph = hready & hsel & htrans[1];
		nxt_s.dwr = hwrite;
		nxt_s.daddr = haddr[7:0];
		if (tx_done) begin
			nxt_s.txsw = tx_word;
			if (tx_ev.jabber) begin
				nxt_s.stat[`DRSW_IS_TJ_BIT] = 1'b1;
				nxt_s.stop = 1'b1;
			end
			if (tx_ev.fifo_empty) begin
				nxt_s.stat[`DRSW_IS_TU_BIT] = 1'b1;
				nxt_s.stat[`DRSW_IS_TI_BIT] = 1'b1;
				nxt_s.susp = 1'b1;
			end
		end
		if (rx_done)
			nxt_s.pending = 1'b1;
		if (s_ff.mem.req && !mem_ack)
			nxt_s.mem = s_ff.mem;
		else
			nxt_s.mem.req = 1'b0;
		case (s_ff.st)
			DRSW_IDLE: begin
				if (rx_start && !s_ff.mem.req) begin
					nxt_s.mem = '{1'b1, 1'b0, s_ff.cur + `DRSW_W1_OFS, 32'h0};
					nxt_s.fetch = 2'h0;
					nxt_s.st = DRSW_NEXT;
				end
			end
			DRSW_NEXT: begin
				if (s_ff.mem.req && mem_ack) begin
					case (s_ff.fetch)
						2'h0: nxt_s.ctl = mem_rdata;
						2'h1: nxt_s.a1 = mem_rdata;
						default: nxt_s.a2 = mem_rdata;
					endcase
					if (s_ff.fetch == 2'h2) begin
						nxt_s.st = (sz1 != '0) ? DRSW_BUF1 : DRSW_BUF2;
					end else begin
						nxt_s.fetch = s_ff.fetch + 2'h1;
						nxt_s.mem.req = 1'b1;
						nxt_s.mem.addr = (s_ff.fetch == 2'h0)
							? s_ff.cur + `DRSW_W2_OFS : s_ff.cur + `DRSW_W3_OFS;
					end
				end
			end
			DRSW_BUF1: begin
				if (s_ff.pending || rx_done)
					nxt_s.st = DRSW_WB;
				else
					nxt_s.st = DRSW_BUF2;
			end
			DRSW_BUF2: begin
				if (sz2 == '0 || s_ff.ctl[`DRSW_RX_CHAIN_BIT]
						|| s_ff.pending || rx_done)
					nxt_s.st = DRSW_WB;
			end
			DRSW_WB: begin
				if (!s_ff.mem.req) begin
					nxt_s.rxsw = rx_word;
					nxt_s.mem = '{1'b1, 1'b1, s_ff.cur, rx_word};
					nxt_s.pending = 1'b0;
					if (s_ff.ctl[`DRSW_RX_END_BIT])
						nxt_s.cur = s_ff.base;
					else if (s_ff.ctl[`DRSW_RX_CHAIN_BIT])
						nxt_s.cur = s_ff.a2;
					else
						nxt_s.cur = s_ff.cur + `DRSW_DESC_STRIDE;
					nxt_s.st = DRSW_IDLE;
				end
			end
			default: nxt_s.st = DRSW_IDLE;
		endcase
		// Read data loaded at the address phase, so it stands in the data phase
		if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				`DRSW_A_BASE: rd = nxt_s.base;
				`DRSW_A_MODE: rd = nxt_s.mode;
				`DRSW_A_CUR:  rd = nxt_s.cur;
				`DRSW_A_STAT: rd = nxt_s.stat;
				`DRSW_A_TXSW: rd = nxt_s.txsw;
				`DRSW_A_RXSW: rd = nxt_s.rxsw;
				default:      rd = '0;
			endcase
			nxt_s.rdata = rd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_ff.rdata;
	assign mem_o = s_ff.mem;
	assign tx_stop = s_ff.stop;
	assign tx_suspend = s_ff.susp;

	chk_tx_summary: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done |=> s_ff.txsw[`DRSW_TX_ES_BIT] == $past(tx_err))
		else $error("error summary mismatch");
	chk_tx_own_clear: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done |=> !s_ff.txsw[`DRSW_OWN_BIT])
		else $error("tx ownership left set");
	chk_jabber_stop: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && tx_ev.jabber |=> tx_stop && s_ff.stat[`DRSW_IS_TJ_BIT]
		&& !s_ff.txsw[`DRSW_TX_HF_BIT])
		else $error("jabber handling wrong");
	chk_uf_suspend: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && tx_ev.fifo_empty |=> tx_suspend
		&& s_ff.stat[`DRSW_IS_TI_BIT] && !s_ff.txsw[`DRSW_TX_LC_BIT])
		else $error("underflow handling wrong");
	chk_ec_tally: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && tx_ev.colls >= `DRSW_COLL_LIMIT |=>
		s_ff.txsw[`DRSW_TX_EC_BIT]
		&& s_ff.txsw[`DRSW_TX_CC_HI:`DRSW_TX_CC_LO] == 4'h0)
		else $error("excess collision report wrong");
	chk_loopback_carrier: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && s_ff.mode[`DRSW_OM_LB_HI:`DRSW_OM_LB_LO]
		== `DRSW_LB_INTERNAL |=> !s_ff.txsw[`DRSW_TX_LO_BIT]
		&& !s_ff.txsw[`DRSW_TX_NC_BIT])
		else $error("carrier bits set in loopback");
	chk_ring_wrap: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_WB && !s_ff.mem.req && s_ff.ctl[`DRSW_RX_END_BIT]
		|=> s_ff.cur == $past(s_ff.base))
		else $error("ring did not wrap");
	chk_rx_runt_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_WB && !s_ff.mem.req && (rx_ev.ovf || rx_ev.wdog)
		|=> !s_ff.rxsw[`DRSW_RX_RF_BIT] && !s_ff.rxsw[`DRSW_OWN_BIT])
		else $error("runt reported on overflow");
	chk_chain_next: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_WB && !s_ff.mem.req && !s_ff.ctl[`DRSW_RX_END_BIT]
		&& s_ff.ctl[`DRSW_RX_CHAIN_BIT] |=> s_ff.cur == $past(s_ff.a2))
		else $error("chained pointer not followed");
	chk_buf1_skip: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_NEXT && s_ff.mem.req && mem_ack
		&& s_ff.fetch == 2'h2 && sz1 == '0 |=> s_ff.st == DRSW_BUF2)
		else $error("empty first buffer not skipped");
	chk_buf2_skip: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_BUF2 && sz2 == '0 |=> s_ff.st == DRSW_WB)
		else $error("empty second buffer not skipped");
	chk_rx_own_clear: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_WB && !s_ff.mem.req |=> s_ff.mem.req
		&& s_ff.mem.wr && !s_ff.mem.wdata[`DRSW_OWN_BIT])
		else $error("rx ownership not returned");
	chk_rx_late_runt: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_WB && !s_ff.mem.req && rx_ev.late_coll
		|=> !s_ff.rxsw[`DRSW_RX_RF_BIT])
		else $error("runt reported after late collision");
	chk_short_runt: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_ff.st == DRSW_WB && !s_ff.mem.req && rx_ev.runt
		&& rx_ev.len < `DRSW_RUNT_SHORT |=> !s_ff.rxsw[`DRSW_RX_FT_BIT]
		&& !s_ff.rxsw[`DRSW_RX_FF_BIT])
		else $error("type or filter bit on short runt");
	chk_tx_late_coll: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && tx_ev.late_coll && !tx_ev.fifo_empty
		|=> s_ff.txsw[`DRSW_TX_LC_BIT])
		else $error("late collision not reported");
	chk_hb_speed: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && !speed_10 |=> !s_ff.txsw[`DRSW_TX_HF_BIT])
		else $error("heartbeat fail outside 10 Mb/s");
	chk_coll_tally: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && tx_ev.colls < `DRSW_COLL_LIMIT
		|=> s_ff.txsw[`DRSW_TX_CC_HI:`DRSW_TX_CC_LO]
		== $past(tx_ev.colls[3:0]))
		else $error("collision tally wrong");
	chk_link_fail: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done && tx_ev.link_fail && s_ff.mode[`DRSW_OM_SYM_BIT]
		|=> s_ff.txsw[`DRSW_TX_LF_BIT])
		else $error("link fail not reported");
	chk_tx_deferred: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done |=> s_ff.txsw[`DRSW_TX_DE_BIT] == $past(tx_ev.deferred))
		else $error("deferred bit wrong");
	chk_tx_word_once: assert property (
		@(posedge hclk) disable iff (!hresetn)
		tx_done |=> s_ff.txsw == $past(tx_word))
		else $error("tx status word not written whole");
endmodule : drsw_top
`default_nettype wire

// >>> sim/drsw_mem_model.sv
// Host memory model holding the descriptor lists of the walker.
// Assumes one request at a time and a byte address inside 256 bytes.
`timescale 1ns/1ps
`default_nettype none
module drsw_mem_model (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire drsw_pkg::drsw_mem_s mem_o,
	output logic                     mem_ack,
	output logic [31:0]              mem_rdata
);
	import drsw_pkg::*;
	logic [31:0] m [0:63];
	int          n_rd;
	int          n_wr;
	int          lag;
	// Descriptors longword aligned, sizes multiples of four
	// Tb hands out ownership in list order, each descriptor just before its walk
	initial begin
		for (int i = 0; i < 64; i++) m[i] = 32'h00000000;
	end
	// Answers after zero, one or two idle cycles in turn
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 32'h00000000;
			n_rd      <= 0;
			n_wr      <= 0;
			lag       <= 0;
		end else if (mem_o.req && !mem_ack && lag >= (n_rd + n_wr) % 3) begin
			mem_ack <= 1'b1;
			lag     <= 0;
			if (mem_o.wr) begin
				m[mem_o.addr[7:2]] <= mem_o.wdata;
				n_wr               <= n_wr + 1;
			end else begin
				mem_rdata <= m[mem_o.addr[7:2]];
				n_rd      <= n_rd + 1;
			end
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			lag       <= mem_o.req ? lag + 1 : 0;
		end
	end
endmodule : drsw_mem_model
`default_nettype wire

// >>> sim/testbench.sv
// Testbench of the ring walker and transmit status write-back.
// Assumes the memory model and the constants header on the path.
`timescale 1ns/1ps
`default_nettype none
`include "drsw_consts.svh"
module testbench;
	import drsw_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_rdata, r;
	logic        hreadyout, hresp, mem_ack, tx_stop, tx_suspend;
	logic        rx_start = 1'b0, rx_done = 1'b0, tx_done = 1'b0;
	logic        speed_10 = 1'b1;
	drsw_mem_s   mem_o;
	drsw_rx_ev_s rx_ev = '0;
	drsw_tx_ev_s tx_ev = '0, e;
	int          n_fail = 0, checked = 0;
	logic [18:0] rxe [4] = '{19'h58040, 19'h28040, 19'h18040, 19'h0E00A};
	logic [31:0] rmsk [4] = '{32'h80000840, 32'h80000800,
		32'h80000840, 32'h80000800};
	logic [31:0] rexp [4] = '{32'h0, 32'h0, 32'h40, 32'h800};
	logic [31:0] rcur [4] = '{32'h0, 32'h30, 32'h40, 32'h0};
	logic [31:0] rnxt [4] = '{32'h30, 32'h40, 32'h0, 32'h30};
	logic [12:0] txe [8] = '{13'h119, 13'h080, 13'hE00, 13'h004,
		13'h002, 13'h1000, 13'hC08, 13'h100};
	logic [31:0] w, msk;
	initial forever #20 hclk = ~hclk;
	drsw_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .mem_o(mem_o), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .rx_start(rx_start), .rx_done(rx_done),
		.rx_ev(rx_ev), .tx_done(tx_done), .tx_ev(tx_ev),
		.speed_10(speed_10), .tx_stop(tx_stop), .tx_suspend(tx_suspend));
	drsw_mem_model mem (.hclk(hclk), .hresetn(hresetn), .mem_o(mem_o),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	task finish_test();
		if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
			n_fail++;
		end
	endtask : chk
	task wt();
		int i;
		i = 0;
		do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin n_fail++; finish_test(); end
	endtask : wt
	task bus(input logic wr, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
		wt();
		htrans <= 2'h0; hwdata <= d;
		wt();
		r = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
		hsel <= 1'b0;
	endtask : bus
	task wait_io(input int nr, input int nw);
		int i;
		for (i = 0; i < 300 && (mem.n_rd < nr || mem.n_wr < nw); i++)
			@(posedge hclk);
		if (mem.n_rd < nr || mem.n_wr < nw) begin
			n_fail++;
			finish_test();
		end
	endtask : wait_io
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		mem.m[0] = 32'h80000000; mem.m[1] = 32'h01000000;
		mem.m[3] = 32'h00000030; mem.m[12] = 32'h80000000;
		mem.m[13] = 32'h00040040; mem.m[16] = 32'h80000000;
		mem.m[17] = 32'h02000040;
		bus(1'b1, {24'h0, `DRSW_A_BASE}, 32'h0);
		bus(1'b0, 32'h00000020, 32'h0);
		chk("unmapped", r, 32'h0);
		for (int k = 0; k < 4; k++) begin
			mem.m[rcur[k] >> 2] = 32'h80000000;
			@(posedge hclk) rx_start <= 1'b1;
			@(posedge hclk) rx_start <= 1'b0;
			wait_io(3 * k + 3, k);
			rx_ev <= drsw_rx_ev_s'(rxe[k]);
			rx_done <= 1'b1;
			@(posedge hclk) rx_done <= 1'b0;
			wait_io(3 * k + 3, k + 1);
			chk("rx status", mem.m[rcur[k] >> 2] & rmsk[k], rexp[k]);
			bus(1'b0, {24'h0, `DRSW_A_CUR}, 32'h0);
			chk("next desc", r, rnxt[k]);
		end
		for (int k = 0; k < 8; k++) begin
			e = drsw_tx_ev_s'(txe[k]);
			w = e.link_fail ? 32'h00800000 : 32'h0;
			if (k == 6) w = 32'h00000400;
			bus(1'b1, {24'h0, `DRSW_A_MODE}, w);
			@(posedge hclk) begin
				tx_ev <= e;
				tx_done <= 1'b1;
				speed_10 <= (k != 7);
			end
			@(posedge hclk) tx_done <= 1'b0;
			w = 32'h0;
			w[14] = e.jabber; w[11] = e.carrier_lost; w[10] = e.no_carrier;
			w[9] = e.late_coll; w[8] = e.colls >= 5'h10;
			w[7] = e.hb_fail & speed_10; w[6:3] = e.colls[3:0];
			w[2] = e.link_fail;
			w[1] = e.fifo_empty; w[0] = e.deferred;
			w[15] = |{w[14], w[11:8], w[1]};
			msk = 32'h8000FFFF;
			if (e.fifo_empty || e.jabber) msk[7] = 1'b0;
			if (e.fifo_empty) msk[9] = 1'b0;
			if (w[8]) msk[6:3] = 4'h0;
			if (k == 6) msk[15] = 1'b0;
			if (k == 6) msk[11:10] = 2'h0;
			bus(1'b0, {24'h0, `DRSW_A_TXSW}, 32'h0);
			chk("tx status", r & msk, w & msk);
			bus(1'b0, {24'h0, `DRSW_A_STAT}, 32'h0);
			chk("int status", r & (e.fifo_empty ? 32'h29 : 32'h28),
				{26'h0, e.fifo_empty, 1'b0, e.jabber, 2'h0, e.fifo_empty});
			chk("stop", {30'h0, tx_stop, tx_suspend},
				{30'h0, e.jabber, e.fifo_empty});
			bus(1'b1, {24'h0, `DRSW_A_STAT}, 32'h29);
			@(posedge hclk);
			chk("stop clr", {30'h0, tx_stop, tx_suspend}, 32'h0);
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
